// file: verilog/dpc_pkg.sv
package dpc_pkg;

  // ram geometry
  localparam int unsigned RAM_BYTES   = 32768;
  localparam int unsigned RAM_WORDS   = RAM_BYTES / 2;
  localparam int unsigned WADDR_W     = 14;               // word index width
  localparam int unsigned ADDR_W      = 20;               // 1 megabyte space
  localparam int unsigned SEG_W       = 7;                // 8K segments in 1 MB
  localparam int unsigned SEG_SHIFT   = 13;               // 8K-byte boundary
  localparam int unsigned RAM_SEGS    = 4;                // 32K / 8K
  localparam logic [ADDR_W-1:0] LOCAL_BASE = 20'h00000;

  // refresh timing: one row refresh every 15.6 us
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned REFRESH_NS     = 15600;
  localparam int unsigned REFRESH_CYCLES = REFRESH_NS * CLK_MHZ / 1000;
  localparam int unsigned RFSH_CNT_W     = 10;
  localparam logic [RFSH_CNT_W-1:0] RFSH_RELOAD = RFSH_CNT_W'(REFRESH_CYCLES - 1);

  // length of one ram cycle, in clocks
  localparam logic [2:0] CYCLE_LEN = 3'h4;

  // reset values
  localparam logic [SEG_W-1:0]   SEG_RESET = 7'h00;

  typedef enum logic [1:0] {
    DPC_IDLE  = 2'b00,
    DPC_LOCAL = 2'b01,
    DPC_SYS   = 2'b10,
    DPC_RFSH  = 2'b11
  } dpc_state_t;

  // one request from either port
  typedef struct packed {
    logic              req;
    logic              we;
    logic [1:0]        be;     // byte enables, bit 0 = even byte
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } dpc_req_t;

  // answer to either port
  typedef struct packed {
    logic        ack;
    logic        refused;
    logic [15:0] rdata;
  } dpc_rsp_t;

endpackage

// file: verilog/dpc_dual_port_dram_controller.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] refresh is timed by an internal counter and always served before pending requests.
// [RULE_02] on a simultaneous request the local processor is granted before the system bus.
// [RULE_03] local and system-bus addresses are decoded by separate logic with separate bases.
// [RULE_04] the local port sees the ram as a fixed window starting at address zero.
// [RULE_05] the system-bus base is a strap setting on any 8K-byte boundary in 1 megabyte.
// [RULE_06] a contiguous range of 8K segments can be closed to the system bus only.
// [RULE_07] the system port takes byte or word accesses; the local port moves 16-bit data.
// [RULE_08] the array holds 32K bytes and addresses beyond it decode as outside the ram.
// [RULE_09] local accesses never touch the shared system bus request.
// [RULE_10] a granted cycle runs to its end before another grant or refresh begins.
module dpc_dual_port_dram_controller (
  input  wire logic                           clk,           // 50 mhz board clock
  input  wire logic                           rst_b,         // async reset, active low
  input  wire dpc_pkg::dpc_req_t              local_req,     // local processor request
  output      dpc_pkg::dpc_rsp_t              local_rsp,     // local processor answer
  input  wire dpc_pkg::dpc_req_t              sys_req,       // system bus slave request
  output      dpc_pkg::dpc_rsp_t              sys_rsp,       // system bus slave answer
  input  wire logic [dpc_pkg::SEG_W-1:0]      sys_base_seg,  // strap: base 8K segment
  input  wire logic [1:0]                     prot_first,    // strap: first closed segment
  input  wire logic [1:0]                     prot_last,     // strap: last closed segment
  input  wire logic                           prot_en,       // strap: protection on
  output      logic                           refresh_busy,  // refresh cycle running
  output      logic                           sys_bus_req    // board asks for shared bus
);

  // ram array, 16K words of two bytes
  logic [15:0] mem [dpc_pkg::RAM_WORDS];

  dpc_pkg::dpc_state_t state;
  dpc_pkg::dpc_state_t next_state;
  logic [2:0]                         cyc_cnt;
  logic [dpc_pkg::RFSH_CNT_W-1:0]     rfsh_cnt;
  logic                               rfsh_pend;
  logic [dpc_pkg::SEG_W-1:0]          base_seg;
  dpc_pkg::dpc_req_t                  cur;
  logic                               cur_local;

  // the base strap is caught after reset release, not under the async reset
  logic strap_taken;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // base strap held from then on; moving the jumpers needs a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_seg <= dpc_pkg::SEG_RESET;
    end else if (!strap_taken) begin
      base_seg <= sys_base_seg;                    // RULE_05
    end
  end

  // local decode: fixed window at zero, 32K long
  wire local_hit = local_req.req &&
                   (local_req.addr[dpc_pkg::ADDR_W-1:15] ==
                    dpc_pkg::LOCAL_BASE[dpc_pkg::ADDR_W-1:15]);          // RULE_04 RULE_08

  // system decode: independent base, window of four 8K segments
  wire [dpc_pkg::SEG_W-1:0] sys_seg = sys_req.addr[dpc_pkg::ADDR_W-1:dpc_pkg::SEG_SHIFT];
  wire [dpc_pkg::SEG_W-1:0] sys_off = sys_seg - base_seg;                 // RULE_03
  wire sys_in_win  = sys_req.req && (sys_off < dpc_pkg::SEG_W'(dpc_pkg::RAM_SEGS)); // RULE_08
  wire [1:0] sys_rel = sys_off[1:0];
  wire sys_closed  = prot_en && (sys_rel >= prot_first) && (sys_rel <= prot_last);  // RULE_06
  wire sys_hit     = sys_in_win && !sys_closed;
  wire sys_refuse  = sys_in_win && sys_closed;

  // word index within the ram for each port
  wire [dpc_pkg::WADDR_W-1:0] local_widx = local_req.addr[14:1];
  wire [dpc_pkg::WADDR_W-1:0] sys_widx   = {sys_rel, sys_req.addr[12:1]};

  // grants; a port whose answer still shows is passed over for that cycle,
  // as its requester lets go only at the edge that samples the answer
  wire local_go   = local_hit && !local_rsp.ack;                           // RULE_10
  wire sys_go     = sys_hit && !sys_rsp.ack;                               // RULE_10
  wire idle       = (state == dpc_pkg::DPC_IDLE);
  wire take_local = idle && (next_state == dpc_pkg::DPC_LOCAL);
  wire take_sys   = idle && (next_state == dpc_pkg::DPC_SYS);
  wire take_rfsh  = idle && (next_state == dpc_pkg::DPC_RFSH);
  wire rfsh_due   = (rfsh_cnt == '0);

  // refresh timer; free running, a request never stops it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rfsh_cnt <= dpc_pkg::RFSH_RELOAD;
    end else if (rfsh_due) begin
      rfsh_cnt <= dpc_pkg::RFSH_RELOAD;
    end else begin
      rfsh_cnt <= rfsh_cnt - 1'b1;
    end
  end

  // pending refresh; set wins over the clear, so a tick that lands on a
  // refresh start costs one extra refresh rather than a lost one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rfsh_pend <= 1'b0;
    end else if (rfsh_due) begin
      rfsh_pend <= 1'b1;                           // RULE_01
    end else if (take_rfsh) begin
      rfsh_pend <= 1'b0;
    end
  end

  // last clock of a four-clock ram cycle
  wire cyc_done = (cyc_cnt == dpc_pkg::CYCLE_LEN - 3'h1);

  // arbiter: refresh, then local, then system; only from idle
  always_comb begin
    next_state = state;
    unique case (state)
      dpc_pkg::DPC_IDLE: begin
        if (rfsh_pend) begin
          next_state = dpc_pkg::DPC_RFSH;          // RULE_01
        end else if (local_go) begin
          next_state = dpc_pkg::DPC_LOCAL;         // RULE_02
        end else if (sys_go) begin
          next_state = dpc_pkg::DPC_SYS;
        end
      end
      dpc_pkg::DPC_LOCAL, dpc_pkg::DPC_SYS, dpc_pkg::DPC_RFSH: begin
        if (cyc_done) begin
          next_state = dpc_pkg::DPC_IDLE;          // RULE_10
        end
      end
    endcase
  end

  // state and cycle counter; the counter restarts at every grant
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= dpc_pkg::DPC_IDLE;
      cyc_cnt <= 3'h0;
    end else begin
      state   <= next_state;
      cyc_cnt <= idle ? 3'h0 : cyc_cnt + 3'h1;
    end
  end

  // request latched at the grant, so a requester may change its lines
  // once answered without disturbing the cycle in flight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur       <= '0;
      cur_local <= 1'b0;
    end else if (take_local) begin
      cur       <= local_req;
      cur.addr  <= {6'h00, local_widx};
      cur.be    <= 2'b11;                        // RULE_07 local path is 16 bits wide
      cur_local <= 1'b1;
    end else if (take_sys) begin
      cur       <= sys_req;
      cur.addr  <= {6'h00, sys_widx};
      cur_local <= 1'b0;
    end
  end

  // end of an access and what it does there
  wire [dpc_pkg::WADDR_W-1:0] cur_widx = cur.addr[dpc_pkg::WADDR_W-1:0];
  wire access_end = cyc_done && (state == dpc_pkg::DPC_LOCAL || state == dpc_pkg::DPC_SYS);
  wire wr_end     = access_end && cur.we;
  wire rd_end     = access_end && !cur.we;
  wire wr_lo      = wr_end && cur.be[0];                                   // RULE_07
  wire wr_hi      = wr_end && cur.be[1];                                   // RULE_07

  // array write with byte lanes at the end of the cycle
  always_ff @(posedge clk) begin
    if (wr_lo) begin
      mem[cur_widx][7:0] <= cur.wdata[7:0];        // RULE_07
    end
    if (wr_hi) begin
      mem[cur_widx][15:8] <= cur.wdata[15:8];      // RULE_07
    end
  end

  // local answer; this port is never refused
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      local_rsp <= '0;
    end else begin
      local_rsp.ack     <= access_end && cur_local;
      local_rsp.refused <= 1'b0;
      if (rd_end) begin
        local_rsp.rdata <= mem[cur_widx];
      end
    end
  end

  // bus answer; a refusal answers at once with no ram cycle, and pulses
  // every other cycle while a refused request is held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_rsp <= '0;
    end else begin
      sys_rsp.ack     <= access_end && !cur_local;
      sys_rsp.refused <= sys_refuse && !sys_rsp.refused;  // RULE_06
      if (rd_end) begin
        sys_rsp.rdata <= mem[cur_widx];
      end
    end
  end

  // refresh flag, raised with the grant so it matches the refresh state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_busy <= 1'b0;
    end else begin
      refresh_busy <= (next_state == dpc_pkg::DPC_RFSH);
    end
  end

  // shared bus request; held low, the ram is private to the board
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_bus_req <= 1'b0;
    end else begin
      sys_bus_req <= 1'b0;                         // RULE_09
    end
  end

endmodule

// file: verification/dpc_sva.sv
`timescale 1ns/1ps
// pin-level watch on decode, arbitration and refresh
module dpc_sva (
  input wire logic              clk,          // board clock
  input wire logic              rst_b,        // async reset, active low
  input wire logic              prot_en,      // protection strap
  input wire logic              refresh_busy, // refresh running
  input wire logic              sys_bus_req,  // shared bus request
  input wire dpc_pkg::dpc_req_t local_req,    // local request
  input wire dpc_pkg::dpc_req_t sys_req,      // bus request
  input wire dpc_pkg::dpc_rsp_t local_rsp,    // local answer
  input wire dpc_pkg::dpc_rsp_t sys_rsp,      // bus answer
  input wire logic [6:0]        sys_base_seg, // base strap
  input wire logic [1:0]        prot_first,   // first closed segment
  input wire logic [1:0]        prot_last     // last closed segment
);
  logic [6:0] off;  // bus segment relative to the base
  logic       shut; // segment lies in the closed range
  // decode helpers; base and range straps are held steady by the bench
  assign off = 7'(sys_req.addr[19:13] - sys_base_seg);
  assign shut = prot_en && off[1:0] >= prot_first && off[1:0] <= prot_last;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RFSH_LEN: assert property ($rose(refresh_busy) |-> refresh_busy[*4])
    else $error("refresh cycle cut short");
  AST_RFSH_DUE: assert property ($fell(refresh_busy) |-> ##[1:900] refresh_busy)
    else $error("refresh overdue");
  AST_LOC_WIN: assert property (local_rsp.ack |-> local_req.addr[19:15] == 5'h00)
    else $error("local answer outside ram");
  AST_SYS_WIN: assert property (sys_rsp.ack |-> off < 7'h04)
    else $error("bus answer outside window");
  AST_SYS_SHUT: assert property (sys_rsp.ack |-> !shut)
    else $error("closed segment answered");
  AST_REFUSE: assert property (sys_rsp.refused |-> shut && off < 7'h04)
    else $error("refusal without cause");
  AST_LOC_OPEN: assert property (!local_rsp.refused) else $error("local refused");
  AST_BUS_FREE: assert property (!sys_bus_req) else $error("shared bus asked");
  AST_ONE_CYC: assert property (local_rsp.ack |=> !sys_rsp.ack [*4])
    else $error("cycles overlap");
endmodule
bind dpc_dual_port_dram_controller dpc_sva dpc_sva_inst (.clk(clk), .rst_b(rst_b),
  .prot_en(prot_en), .refresh_busy(refresh_busy), .sys_bus_req(sys_bus_req),
  .local_req(local_req), .sys_req(sys_req), .local_rsp(local_rsp), .sys_rsp(sys_rsp),
  .sys_base_seg(sys_base_seg), .prot_first(prot_first), .prot_last(prot_last));

// file: verification/dpc_requester.sv
`timescale 1ns/1ps
// requester: holds a request until answered, refused or 40 cycles pass, then drops it
module dpc_requester (
  input  wire logic              clk, // board clock
  input  wire dpc_pkg::dpc_rsp_t rsp, // controller answer
  output      dpc_pkg::dpc_req_t req  // request to controller
);
  initial req = '0;
  // op = {we, be}; got = {refused, ack}, zero if silent for 40 cycles
  task automatic access(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic [1:0] got);
    @(posedge clk);
    req <= {1'h1, op, a, d};
    got = 2'h0;
    for (int n = 0; n < 40 && got == 2'h0; n++) begin
      @(posedge clk);
      got = {rsp.refused, rsp.ack};
    end
    rd = rsp.rdata;
    req <= {1'h0, ~op, ~a, ~d}; // released lines never keep the old value
  endtask
endmodule

// file: verification/dpc_dual_port_dram_controller_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module dpc_dual_port_dram_controller_tb;
  localparam logic [19:0] SB = 20'ha000; // bus base, segment 5
  logic              clk, rst_b, prot_en, rf_seen, refresh_busy, sys_bus_req;
  logic [1:0]        prot_first, prot_last, got;
  logic [6:0]        sys_base_seg;
  logic [15:0]       rd;
  dpc_pkg::dpc_req_t local_req, sys_req;
  dpc_pkg::dpc_rsp_t local_rsp, sys_rsp;
  int                checked = 0, miscompares = 0;
  dpc_dual_port_dram_controller dpc_dual_port_dram_controller_inst (.clk(clk), .rst_b(rst_b),
    .local_req(local_req), .local_rsp(local_rsp), .sys_req(sys_req), .sys_rsp(sys_rsp),
    .sys_base_seg(sys_base_seg), .prot_first(prot_first), .prot_last(prot_last),
    .prot_en(prot_en), .refresh_busy(refresh_busy), .sys_bus_req(sys_bus_req));
  dpc_requester dpc_requester_inst (.clk(clk), .rsp(local_rsp), .req(local_req));
  dpc_requester dpc_requester_sys_inst (.clk(clk), .rsp(sys_rsp), .req(sys_req));
  // one access on the bus port (s = 1) or the local port
  task automatic acc(input logic s, input logic [2:0] op, input logic [19:0] a,
                     input logic [15:0] d);
    if (s) dpc_requester_sys_inst.access(op, a, d, rd, got);
    else dpc_requester_inst.access(op, a, d, rd, got);
  endtask
  // both ports map one word; an even bus byte merges into it
  task automatic t_ports();
    acc(1'h0, 3'h7, 20'h00002, 16'h1234);
    acc(1'h1, 3'h5, SB + 20'h00002, 16'hcdab);
    `CHK("bus byte write", 2'h1, got)
    acc(1'h0, 3'h3, 20'h00002, 16'h0000);
    `CHK("merged word", 16'h12ab, rd)
    acc(1'h0, 3'h3, 20'h08000, 16'h0000);
    `CHK("local past ram", 2'h0, got)
    acc(1'h1, 3'h3, SB + 20'h08000, 16'h0000);
    `CHK("bus past ram", 2'h0, got)
  endtask
  // segments 1..2 closed to the bus only
  task automatic t_protect();
    @(posedge clk) prot_en <= 1'h1;
    acc(1'h1, 3'h3, SB + 20'h02000, 16'h0000);
    `CHK("closed segment", 2'h2, got)
    acc(1'h1, 3'h3, SB + 20'h06000, 16'h0000);
    `CHK("open segment", 2'h1, got)
    acc(1'h0, 3'h3, 20'h02000, 16'h0000);
    `CHK("local in closed", 2'h1, got)
    @(posedge clk) prot_en <= 1'h0;
  endtask
  // same-edge requests: the bus read must see the local write
  task automatic t_prio();
    logic [15:0] r2;
    logic [1:0]  g2;
    fork
      dpc_requester_inst.access(3'h7, 20'h00010, 16'h5a5a, rd, got);
      dpc_requester_sys_inst.access(3'h3, SB + 20'h00010, 16'h0000, r2, g2);
    join
    `CHK("bus after local", 16'h5a5a, r2)
  endtask
  // steady local traffic longer than one refresh period
  task automatic t_rfsh();
    repeat (150) acc(1'h0, 3'h3, 20'h00010, 16'h0000);
    `CHK("refresh seen", 1'h1, rf_seen)
    `CHK("shared bus idle", 1'h0, sys_bus_req)
  endtask
  always @(posedge clk) if (refresh_busy === 1'h1) rf_seen <= 1'h1;
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // the tests need about 1200 cycles
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {rst_b, prot_en, rf_seen} = 3'h0;
    {sys_base_seg, prot_first, prot_last} = {7'h05, 2'h1, 2'h2};
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    t_ports();
    t_protect();
    t_prio();
    t_rfsh();
    print_verdict();
  end
endmodule
